// ### ucr_pkg.sv
// Purpose: Shared constants and types for the serial channel control registers.
// Assumes: Classic Wishbone slave with 32-bit data, one register per aligned word.
// Notes:   Register indexes are multiplied by four to form byte addresses.
package ucr_pkg;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [2:0] IDX_DATA   = 3'h0;
    localparam logic [2:0] IDX_INTEN  = 3'h1;
    localparam logic [2:0] IDX_FIFO   = 3'h2;
    localparam logic [2:0] IDX_LINE   = 3'h3;
    localparam logic [2:0] IDX_EVENTS = 3'h4;
    localparam logic [2:0] IDX_STATE  = 3'h5;
    localparam int         ADDR_LSB   = 2;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] INTEN_RST = 8'h0c;
    localparam logic [7:0] LINE_RST  = 8'h00;
    localparam logic [7:0] ISTAT_RST = 8'h00;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int IE_RXRDY = 0;
    localparam int IE_TXRDY = 1;
    localparam int IE_RXST  = 2;
    localparam int IE_MODEM = 3;
    localparam int IE_SLEEP = 4;
    localparam int FC_EN    = 0;
    localparam int FC_FLRX  = 1;
    localparam int FC_FLTX  = 2;
    localparam int LC_STOP  = 2;
    localparam int LC_PEN   = 3;
    localparam int LC_BRK   = 6;
    localparam int LC_DLE   = 7;

    // Event bits in the event input.
    localparam int EV_LINEERR = 0;
    localparam int EV_RXAVAIL = 1;
    localparam int EV_RXTMO   = 2;
    localparam int EV_THREMPT = 3;
    localparam int EV_MODEM   = 4;
    localparam int EV_ADDR9   = 5;

    // ----------------------------------------
    // Interrupt codes and thresholds
    // ----------------------------------------
    localparam logic [5:0] IC_NONE  = 6'h01;
    localparam logic [5:0] IC_LINE  = 6'h06;
    localparam logic [5:0] IC_RXAV  = 6'h04;
    localparam logic [5:0] IC_RXTMO = 6'h0c;
    localparam logic [5:0] IC_THRE  = 6'h02;
    localparam logic [5:0] IC_MODEM = 6'h00;
    localparam logic [1:0] FIFO_ON_BITS = 2'h3;
    localparam logic [4:0] TRIG_1  = 5'h01;
    localparam logic [4:0] TRIG_4  = 5'h04;
    localparam logic [4:0] TRIG_8  = 5'h08;
    localparam logic [4:0] TRIG_14 = 5'h0e;
    localparam logic [4:0] LOW_TRIG = 5'h01;

    // Stop length in half bits.
    localparam logic [2:0] STOP_ONE  = 3'h2;
    localparam logic [2:0] STOP_ONEH = 3'h3;
    localparam logic [2:0] STOP_TWO  = 3'h4;

    typedef enum logic [2:0] {
        PAR_NONE  = 3'b001,
        PAR_CALC  = 3'b010,
        PAR_FORCE = 3'b100
    } ucr_par_t;

    // Frame settings handed to the shifters.
    typedef struct packed {
        logic [3:0] dataBits;
        logic [2:0] stopHalves;
        ucr_par_t   parMode;
        logic       parOdd;
        logic       parForced;
        logic       brk;
    } ucr_frame_t;

    // Queue control handed to the queues.
    typedef struct packed {
        logic       fifoMode;
        logic       flushRx;
        logic       flushTx;
        logic [4:0] upperTrig;
        logic [4:0] lowerTrig;
    } ucr_queue_t;

    typedef struct packed {
        logic [1:0] rsync;
        logic [7:0] inten;
        logic [7:0] line;
        logic       fifoMode;
        logic [1:0] trigSel;
        logic       flushRx;
        logic       flushTx;
        logic [7:0] istat;
        logic       irq;
        logic       rtsOn;
        logic       clkEn;
        logic       ack;
        logic [31:0] rdat;
        logic [7:0] dll;
        logic [7:0] divisor_high_byte;
        ucr_frame_t frame;
        ucr_queue_t queue;
    } ucr_state_t;

endpackage

// ### ucr_regs.sv
// Purpose: Control, interrupt and framing registers of one serial channel.
// Assumes: Wishbone classic slave; queue, shifter and modem logic live outside.
// Notes:   Answers every access with ack one cycle after the request arrives.
//
// What this block does
// - Interrupt enable at 1, resets to 0x0c.
// - Enable bit 0 gates receiver ready interrupt.
// - Enable bit 1 gates holding empty interrupt.
// - Enable bit 2 gates line error interrupt.
// - Enable bit 3 gates modem change interrupt.
// - Enable bit 4 stops channel clock (sleep).
// - Bit 1 flushes receive queue, FIFO mode only.
// - Mode change flushes receive queue automatically.
// - Bit 2 flushes transmit queue likewise.
// - Bits 7:6 pick threshold 1, 4, 8, 14.
// - Request-to-send hysteresis between upper and lower thresholds.
// - Byte mode forces all thresholds to one.
// - Status at 2 shows top source, resets 0x00.
// - Line error highest, then data or timeout.
// - Holding empty priority three, modem lowest.
// - Status bit 0 high when nothing pending.
// - Line bits 1:0 set five to eight bits.
// - Line bit 2 selects one, 1.5 or 2 stops.
// - Line bits 5:3 choose parity kind.
// - Nine-bit mode disables parity entirely.
// - Line bit 6 forces break on output.
// - Line bit 7 maps divisor latch; resets 0x00.
// - Reset starts channel in byte mode.
`timescale 1ns/1ps
module ucr_regs #(
    parameter int DW = 32
) (
    // Clock and reset
    input  wire logic              mclk,
    input  wire logic              resetn,
    // Wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [4:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [DW-1:0]     wb_dat_i,
    output logic      [DW-1:0]     wb_dat_o,
    output logic                   wb_ack_o,
    // Channel status
    input  wire logic [5:0]        events,
    input  wire logic [4:0]        rxFill,
    input  wire logic              nineBitMode,
    // Channel control
    output ucr_pkg::ucr_frame_t    frame,
    output ucr_pkg::ucr_queue_t    queue,
    output logic                   channelClkEn,
    output logic                   rtsActive,
    output logic                   irq
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [4:0] upperOf(input logic fifoOn, input logic [1:0] sel);
        logic [4:0] t;
        t = ucr_pkg::TRIG_1;
        if (fifoOn) begin
            unique case (sel)
                2'h0: t = ucr_pkg::TRIG_1;
                2'h1: t = ucr_pkg::TRIG_4;
                2'h2: t = ucr_pkg::TRIG_8;
                2'h3: t = ucr_pkg::TRIG_14;
            endcase
        end
        return t;
    endfunction

    ucr_pkg::ucr_state_t s_q;
    ucr_pkg::ucr_state_t s_d;

    logic       rstn;
    logic       req;
    logic       wr;
    logic       rd;
    logic [2:0] idx;
    logic [7:0] wb0;
    logic [7:0] en;
    logic [5:0] code;
    logic       newFifo;

    assign rstn = rsync_q[1];
    assign req  = wb_cyc_i && wb_stb_i && !s_q.ack;
    assign wr   = req && wb_we_i && wb_sel_i[0];
    assign rd   = req && !wb_we_i;
    assign idx  = wb_adr_i[4:ucr_pkg::ADDR_LSB];
    assign wb0  = wb_dat_i[7:0];

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    logic [1:0] rsync_q;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rsync_q <= 2'h0;
        end else begin
            rsync_q <= {rsync_q[0], 1'b1};
        end
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        s_d       = s_q;
        s_d.rsync = {2{rsync_q[1]}};
        s_d.ack   = req;
        s_d.flushRx = 1'b0;
        s_d.flushTx = 1'b0;
        en   = s_q.inten;
        code = ucr_pkg::IC_NONE;
        newFifo = s_q.fifoMode;

        if (wr) begin
            unique case (idx)
                ucr_pkg::IDX_DATA: begin
                    if (s_q.line[ucr_pkg::LC_DLE]) s_d.dll = wb0;
                end
                ucr_pkg::IDX_INTEN: begin
                    if (s_q.line[ucr_pkg::LC_DLE]) begin
                        s_d.divisor_high_byte = wb0;
                    end else begin
                        s_d.inten = {3'h0, wb0[4:0]};
                    end
                end
                ucr_pkg::IDX_FIFO: begin
                    newFifo     = wb0[ucr_pkg::FC_EN];
                    s_d.fifoMode = newFifo;
                    s_d.trigSel = wb0[7:6];
                    // Flush applies only in FIFO mode; a mode change always flushes receive.
                    s_d.flushRx = (newFifo && wb0[ucr_pkg::FC_FLRX]) || (newFifo != s_q.fifoMode);
                    s_d.flushTx = newFifo && wb0[ucr_pkg::FC_FLTX];
                end
                ucr_pkg::IDX_LINE: s_d.line = wb0;
                default: ;
            endcase
        end

        // Priority encoder of enabled sources.
        if (en[ucr_pkg::IE_RXST] && (events[ucr_pkg::EV_LINEERR] || events[ucr_pkg::EV_ADDR9])) begin
            code = ucr_pkg::IC_LINE;
        end else if (en[ucr_pkg::IE_RXRDY] && events[ucr_pkg::EV_RXAVAIL]) begin
            code = ucr_pkg::IC_RXAV;
        end else if (en[ucr_pkg::IE_RXRDY] && events[ucr_pkg::EV_RXTMO]) begin
            code = ucr_pkg::IC_RXTMO;
        end else if (en[ucr_pkg::IE_TXRDY] && events[ucr_pkg::EV_THREMPT]) begin
            code = ucr_pkg::IC_THRE;
        end else if (en[ucr_pkg::IE_MODEM] && events[ucr_pkg::EV_MODEM]) begin
            code = ucr_pkg::IC_MODEM;
        end
        s_d.istat = {(s_q.fifoMode ? ucr_pkg::FIFO_ON_BITS : 2'h0), code};
        s_d.irq   = (code != ucr_pkg::IC_NONE);

        s_d.clkEn = !s_q.inten[ucr_pkg::IE_SLEEP];

        // Flow control hysteresis on receive fill.
        s_d.queue.upperTrig = upperOf(s_q.fifoMode, s_q.trigSel);
        s_d.queue.lowerTrig = ucr_pkg::LOW_TRIG;
        s_d.queue.fifoMode  = s_q.fifoMode;
        s_d.queue.flushRx   = s_q.flushRx;
        s_d.queue.flushTx   = s_q.flushTx;
        if (rxFill >= s_q.queue.upperTrig) begin
            s_d.rtsOn = 1'b0;
        end else if (rxFill < s_q.queue.lowerTrig || rxFill == s_q.queue.lowerTrig - 5'h01) begin
            s_d.rtsOn = 1'b1;
        end

        // Frame format.
        s_d.frame.dataBits = 4'h5 + {2'h0, s_q.line[1:0]};
        if (!s_q.line[ucr_pkg::LC_STOP]) begin
            s_d.frame.stopHalves = ucr_pkg::STOP_ONE;
        end else begin
            s_d.frame.stopHalves = (s_q.line[1:0] == 2'h0) ? ucr_pkg::STOP_ONEH : ucr_pkg::STOP_TWO;
        end
        if (nineBitMode || !s_q.line[ucr_pkg::LC_PEN]) begin
            s_d.frame.parMode = ucr_pkg::PAR_NONE;
        end else if (s_q.line[5]) begin
            s_d.frame.parMode = ucr_pkg::PAR_FORCE;
        end else begin
            s_d.frame.parMode = ucr_pkg::PAR_CALC;
        end
        s_d.frame.parOdd    = !s_q.line[4];
        s_d.frame.parForced = !s_q.line[4];
        s_d.frame.brk       = s_q.line[ucr_pkg::LC_BRK];

        // Read mux; reads have no side effects on sources.
        s_d.rdat = '0;
        if (rd) begin
            unique case (idx)
                ucr_pkg::IDX_DATA:   s_d.rdat[7:0] = s_q.line[ucr_pkg::LC_DLE] ? s_q.dll : 8'h00;
                ucr_pkg::IDX_INTEN:  s_d.rdat[7:0] = s_q.line[ucr_pkg::LC_DLE] ? s_q.divisor_high_byte : s_q.inten;
                ucr_pkg::IDX_FIFO:   s_d.rdat[7:0] = s_q.istat;
                ucr_pkg::IDX_LINE:   s_d.rdat[7:0] = s_q.line;
                ucr_pkg::IDX_EVENTS: s_d.rdat[5:0] = events;
                ucr_pkg::IDX_STATE:  s_d.rdat[4:0] = rxFill;
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s_q          <= '0;
            s_q.rsync    <= 2'h3;
            s_q.inten    <= ucr_pkg::INTEN_RST;
            s_q.line     <= ucr_pkg::LINE_RST;
            s_q.istat    <= ucr_pkg::ISTAT_RST;
            s_q.fifoMode <= 1'b0;
            s_q.rtsOn    <= 1'b1;
            s_q.clkEn    <= 1'b1;
            s_q.frame.parMode  <= ucr_pkg::PAR_NONE;
            s_q.frame.dataBits <= 4'h5;
            s_q.frame.stopHalves <= ucr_pkg::STOP_ONE;
            s_q.queue.upperTrig <= ucr_pkg::TRIG_1;
            s_q.queue.lowerTrig <= ucr_pkg::LOW_TRIG;
        end else begin
            s_q <= s_d;
        end
    end

    assign wb_dat_o     = s_q.rdat;
    assign wb_ack_o     = s_q.ack;
    assign frame        = s_q.frame;
    assign queue        = s_q.queue;
    assign channelClkEn = s_q.clkEn;
    assign rtsActive    = s_q.rtsOn;
    assign irq          = s_q.irq;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence fifoWrite;
        wr && idx == ucr_pkg::IDX_FIFO;
    endsequence

    a_ack_single: assert property (@(posedge mclk) disable iff (!rstn)
        req |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not a single pulse");
    a_sleep_clock: assert property (@(posedge mclk) disable iff (!rstn)
        s_q.inten[ucr_pkg::IE_SLEEP] |=> !channelClkEn) else $error("sleep left clock on");
    a_flush_byte: assert property (@(posedge mclk) disable iff (!rstn)
        fifoWrite and (!wb0[ucr_pkg::FC_EN] && !s_q.fifoMode) |=> !s_q.flushRx && !s_q.flushTx)
        else $error("flush in byte mode");
    a_mode_flush: assert property (@(posedge mclk) disable iff (!rstn)
        fifoWrite and (wb0[ucr_pkg::FC_EN] != s_q.fifoMode) |=> s_q.flushRx ##1 queue.flushRx ##1 !queue.flushRx)
        else $error("mode change did not flush");
    a_byte_trig: assert property (@(posedge mclk) disable iff (!rstn)
        !s_q.fifoMode |=> queue.upperTrig == ucr_pkg::TRIG_1) else $error("byte trigger not one");
    a_status_idle: assert property (@(posedge mclk) disable iff (!rstn)
        irq |-> s_q.istat[0] == 1'b0) else $error("pending bit wrong");
    a_line_first: assert property (@(posedge mclk) disable iff (!rstn)
        s_q.inten[ucr_pkg::IE_RXST] && events[ucr_pkg::EV_LINEERR] |=> s_q.istat[5:0] == ucr_pkg::IC_LINE)
        else $error("line error not first");
    a_rx_masked: assert property (@(posedge mclk) disable iff (!rstn)
        !s_q.inten[ucr_pkg::IE_RXRDY] |=> s_q.istat[5:0] != ucr_pkg::IC_RXAV) else $error("masked rx shown");
    a_rts_upper: assert property (@(posedge mclk) disable iff (!rstn)
        rxFill >= queue.upperTrig |=> !rtsActive) else $error("rts kept on at upper");
    a_nine_nopar: assert property (@(posedge mclk) disable iff (!rstn)
        nineBitMode |=> frame.parMode == ucr_pkg::PAR_NONE) else $error("parity in nine-bit");

endmodule

// ### ucr_far_model.sv
// Purpose: Far-side model of the receive queue and event sources of the channel.
// Assumes: The bench steers the event levels and the receive fill count.
// Notes:   Fill is emptied by the flush pulse, as the real queue would.
`timescale 1ns/1ps
module ucr_far_model (
    // Clock and reset
    input  wire logic              mclk,
    input  wire logic              resetn,
    // Bench commands
    input  wire logic [5:0]        evSet,
    input  wire logic [4:0]        fillSet,
    input  wire logic              fillLoad,
    // Block control
    input  wire ucr_pkg::ucr_queue_t queue,
    // Block status
    output logic      [5:0]        events,
    output logic      [4:0]        rxFill
);
    // ----------------------------------------
    // Queue fill
    // ----------------------------------------
    assign events = evSet;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rxFill <= 5'h00;
        end else if (queue.flushRx) begin
            rxFill <= 5'h00;
        end else if (fillLoad) begin
            rxFill <= fillSet;
        end
    end
endmodule

// ### uart_control_and_interrupt_regs_test.sv
// Purpose: Self-checking bench for the channel control registers.
// Assumes: Wishbone classic master; answer waited for, never assumed.
// Notes:   Read data is taken in the cycle in which ack stands high.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checkCount++; if ((g) !== (e)) begin miscompares++; \
    $display("BAD %s exp %0h got %0h", nm, e, g); end end
module uart_control_and_interrupt_regs_test;
    logic mclk = 0, resetn = 0, wbCyc = 0, wbStb = 0, wbWe = 0, wbAck, nineBit = 0, fillLoad = 0;
    logic [4:0] wbAdr = 5'h00, fillSet = 5'h00, rxFill;
    logic [3:0] wbSel = 4'h0;
    logic [31:0] wbDat = 32'h0, wbDatO, rd;
    logic [5:0] evSet = 6'h00, events;
    logic [7:0] lc;
    logic channelClkEn, rtsActive, irq;
    ucr_pkg::ucr_frame_t frame;
    ucr_pkg::ucr_queue_t queue;
    int miscompares = 0, checkCount = 0, rxFl = 0, txFl = 0, i;
    logic [5:0] codeTab [6] = '{ucr_pkg::IC_LINE, ucr_pkg::IC_RXAV, ucr_pkg::IC_RXTMO,
                                ucr_pkg::IC_THRE, ucr_pkg::IC_MODEM, ucr_pkg::IC_LINE};
    int maskTab [6] = '{2, 0, 0, 1, 3, 2};
    logic [4:0] trigTab [4] = '{ucr_pkg::TRIG_1, ucr_pkg::TRIG_4, ucr_pkg::TRIG_8, ucr_pkg::TRIG_14};

    always #20 mclk = ~mclk;

    ucr_regs u_dut (.mclk(mclk), .resetn(resetn), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
        .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
        .events(events), .rxFill(rxFill), .nineBitMode(nineBit), .frame(frame), .queue(queue),
        .channelClkEn(channelClkEn), .rtsActive(rtsActive), .irq(irq));
    ucr_far_model u_far (.mclk(mclk), .resetn(resetn), .evSet(evSet), .fillSet(fillSet),
        .fillLoad(fillLoad), .queue(queue), .events(events), .rxFill(rxFill));

    // Flush pulses are counted, since they stand for one cycle only.
    always @(posedge mclk) begin
        if (queue.flushRx === 1'b1) rxFl++;
        if (queue.flushTx === 1'b1) txFl++;
    end

    // ----------------------------------------
    // Bus tasks
    // ----------------------------------------
    task automatic acc(input logic we, input logic [2:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        wbCyc <= 1'b1; wbStb <= 1'b1; wbWe <= we; wbSel <= 4'hf;
        wbAdr <= {idx, 2'b00}; wbDat <= {24'h000000, wd};
        do begin @(posedge mclk); n++; end while (wbAck !== 1'b1 && n < 40);
        if (n >= 40) begin miscompares++; $display("BAD ack exp 1 got 0"); end
        rd = wbDatO;
        wbCyc <= 1'b0; wbStb <= 1'b0; wbWe <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask

    task automatic setFill(input logic [4:0] v);
        fillSet <= v; fillLoad <= 1'b1;
        @(posedge mclk);
        fillLoad <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask

    // Status is registered from the event levels, so let it settle before reading.
    task automatic setEv(input logic [5:0] v);
        evSet <= v;
        repeat (2) @(posedge mclk);
    endtask

    task automatic report_and_stop;
        $display("checks %0d miscompares %0d", checkCount, miscompares);
        if (miscompares == 0 && checkCount > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        report_and_stop;
    end

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge mclk);
        resetn <= 1'b1;
        repeat (5) @(posedge mclk);
        acc(0, ucr_pkg::IDX_INTEN, 8'h00); `CHK("inten rst", 8'h0c, rd[7:0])
        acc(0, ucr_pkg::IDX_LINE, 8'h00); `CHK("line rst", 8'h00, rd[7:0])
        acc(0, ucr_pkg::IDX_FIFO, 8'h00); `CHK("stat rst", 8'h01, rd[7:0])
        `CHK("mode rst", 1'b0, queue.fifoMode)
        `CHK("clk rst", 1'b1, channelClkEn)
        acc(1, ucr_pkg::IDX_INTEN, 8'hff); acc(0, ucr_pkg::IDX_INTEN, 8'h00);
        `CHK("inten rw", 8'h1f, rd[7:0])
        `CHK("sleep", 1'b0, channelClkEn)
        acc(1, ucr_pkg::IDX_INTEN, 8'h0f); `CHK("wake", 1'b1, channelClkEn)
        for (i = 0; i < 6; i++) begin
            setEv(6'h01 << i);
            acc(0, ucr_pkg::IDX_FIFO, 8'h00); `CHK("code", {2'b00, codeTab[i]}, rd[7:0])
            `CHK("irq on", 1'b1, irq)
            acc(1, ucr_pkg::IDX_INTEN, 8'h0f & ~(8'h01 << maskTab[i]));
            acc(0, ucr_pkg::IDX_FIFO, 8'h00); `CHK("masked", 8'h01, rd[7:0])
            `CHK("irq off", 1'b0, irq)
            acc(1, ucr_pkg::IDX_INTEN, 8'h0f);
        end
        setEv(6'h3f); acc(0, ucr_pkg::IDX_FIFO, 8'h00); `CHK("prio1", 8'h06, rd[7:0])
        acc(0, ucr_pkg::IDX_EVENTS, 8'h00); `CHK("events rd", 6'h3f, rd[5:0])
        setEv(6'h1e); acc(0, ucr_pkg::IDX_FIFO, 8'h00); `CHK("prio2", 8'h04, rd[7:0])
        setEv(6'h18); acc(0, ucr_pkg::IDX_FIFO, 8'h00); `CHK("prio3", 8'h02, rd[7:0])
        evSet <= 6'h00;
        acc(1, ucr_pkg::IDX_FIFO, 8'h01); acc(0, ucr_pkg::IDX_FIFO, 8'h00);
        `CHK("fifo stat", 8'hc1, rd[7:0])
        `CHK("auto flush", 1, rxFl)
        for (i = 0; i < 4; i++) begin
            acc(1, ucr_pkg::IDX_FIFO, {i[1:0], 6'h01});
            `CHK("upper", trigTab[i], queue.upperTrig)
            `CHK("lower", ucr_pkg::LOW_TRIG, queue.lowerTrig)
        end
        `CHK("no flush", 1, rxFl)
        acc(1, ucr_pkg::IDX_FIFO, 8'h41);
        setFill(5'h03); `CHK("rts 3", 1'b1, rtsActive)
        acc(0, ucr_pkg::IDX_STATE, 8'h00); `CHK("fill rd", 5'h03, rd[4:0])
        setFill(5'h04); `CHK("rts 4", 1'b0, rtsActive)
        setFill(5'h02); `CHK("rts 2", 1'b0, rtsActive)
        setFill(5'h00); `CHK("rts 0", 1'b1, rtsActive)
        acc(1, ucr_pkg::IDX_FIFO, 8'h43); `CHK("rx flush", 2, rxFl)
        acc(1, ucr_pkg::IDX_FIFO, 8'h45); `CHK("tx flush", 1, txFl)
        acc(1, ucr_pkg::IDX_FIFO, 8'hc0); `CHK("byte flush", 3, rxFl)
        `CHK("byte trig", ucr_pkg::TRIG_1, queue.upperTrig)
        acc(1, ucr_pkg::IDX_FIFO, 8'hc6); `CHK("byte rx", 3, rxFl)
        `CHK("byte tx", 1, txFl)
        acc(0, ucr_pkg::IDX_FIFO, 8'h00); `CHK("byte stat", 8'h01, rd[7:0])
        for (i = 0; i < 64; i++) begin
            lc = {2'b00, i[5:0]};
            acc(1, ucr_pkg::IDX_LINE, lc); acc(0, ucr_pkg::IDX_LINE, 8'h00);
            `CHK("line rw", lc, rd[7:0])
            `CHK("bits", 4'(5 + lc[1:0]), frame.dataBits)
            `CHK("stop", !lc[2] ? ucr_pkg::STOP_ONE : (lc[1:0] == 2'b00 ? ucr_pkg::STOP_ONEH
                : ucr_pkg::STOP_TWO), frame.stopHalves)
            `CHK("par", !lc[3] ? ucr_pkg::PAR_NONE : (lc[5] ? ucr_pkg::PAR_FORCE
                : ucr_pkg::PAR_CALC), frame.parMode)
            if (lc[5:3] == 3'b001 || lc[5:3] == 3'b011) `CHK("odd", !lc[4], frame.parOdd)
            if (lc[5:3] == 3'b101 || lc[5:3] == 3'b111) `CHK("forced", !lc[4], frame.parForced)
        end
        nineBit <= 1'b1; acc(1, ucr_pkg::IDX_LINE, 8'h2b);
        `CHK("nine", ucr_pkg::PAR_NONE, frame.parMode)
        acc(1, ucr_pkg::IDX_LINE, 8'h43); `CHK("brk", 1'b1, frame.brk)
        acc(1, ucr_pkg::IDX_LINE, 8'h83); acc(1, ucr_pkg::IDX_INTEN, 8'h55);
        acc(0, ucr_pkg::IDX_INTEN, 8'h00); `CHK("dlm", 8'h55, rd[7:0])
        acc(1, ucr_pkg::IDX_LINE, 8'h03); acc(0, ucr_pkg::IDX_INTEN, 8'h00);
        `CHK("ien back", 8'h0f, rd[7:0])
        acc(0, 3'h7, 8'h00); `CHK("unmapped", 32'h0, rd)
        report_and_stop;
    end
endmodule
